// [clk_ctrl_params.svh]
// Constants for the oscillator, PLL and clock select control block.
// Assumes a 250 MHz core clock and an 8-bit special function register port.
`ifndef CLK_CTRL_PARAMS_SVH
`define CLK_CTRL_PARAMS_SVH
`define ADDR_OSC_PLL_CTRL   16'hFFA0
`define ADDR_MAIN_CLK_MODE  16'hFFA1
`define ADDR_MAIN_OSC_CTRL  16'hFFA2
`define ADDR_STAB_STATUS    16'hFFA3
`define RST_OSC_PLL_CTRL    8'h00
`define VAL_OSC_PLL_STABLE  8'h80
`define RST_MAIN_CLK_MODE   8'h00
`define RST_MAIN_OSC_CTRL   8'h80
`define RST_STAB_STATUS     8'h00
`define BIT_HS_STABLE       7
`define BIT_PLL_STATUS      5
`define BIT_PLL_ENABLE      4
`define BIT_PLL_SELECT      3
`define BIT_LS_STOP         1
`define BIT_HS_STOP         0
`define BIT_MAIN_OSC_STOP   7
`define BIT_SYS_SELECT      2
`define BIT_MAIN_STATUS     1
`define BIT_MAIN_SOURCE     0
`define CLK_MHZ             250
`define PLL_WAIT_US         10
`define PLL_WAIT_CYC        (`PLL_WAIT_US * `CLK_MHZ)
`define PLL_UP_CYC          1
`define PLL_DOWN_CYC        3
`define STAB_STEPS          5
`endif

// [clk_ctrl_pkg.sv]
// Types shared by the clock control block.
// Assumes the constants header is included where numbers are needed.
package clk_ctrl_pkg;
    typedef enum logic [1:0] {
        PLL_THROUGH = 2'b00,
        PLL_WAITING = 2'b01,
        PLL_LOCKED  = 2'b11,
        PLL_LEAVING = 2'b10
    } pll_state_type;
    typedef logic [7:0] reg8_type;
endpackage

// [stab_counter.sv]
// Crystal stabilisation counter: counts crystal ticks and raises status steps.
// Assumes xtal_tick is a one-cycle pulse per crystal cycle, synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
`include "clk_ctrl_params.svh"
module stab_counter
    import clk_ctrl_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       clk_en,
    input  wire logic       clear,
    input  wire logic       xtal_tick,
    output var  logic [4:0] status_r
);
    logic [16:0] count_r;
    logic [16:0] count_nxt;
    logic [4:0]  reached;
    localparam int THRESH_EXP [5] = '{11, 13, 14, 15, 16};

    // Saturate so the top step never wraps back to zero
    assign count_nxt = count_r[16] ? count_r : count_r + 17'h00001;

    genvar i;
    generate
        for (i = 0; i < `STAB_STEPS; i++) begin : g_step
            // Bit 4 is the first threshold, bit 0 the last
            assign reached[4 - i] = (count_r >= (17'h00001 << THRESH_EXP[i]));
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (reset || (clk_en && clear)) begin
            count_r  <= 17'h00000;
            status_r <= 5'h00;
        end else if (clk_en) begin
            if (xtal_tick)
                count_r <= count_nxt;
            status_r <= status_r | reached;
        end
    end
endmodule // stab_counter
`default_nettype wire

// [clk_ctrl.sv]
// Oscillator start/stop, PLL enable and mode, main and peripheral clock select.
// Assumes a synchronous 8-bit register port and oscillator status inputs.
`timescale 1ns/1ns
`default_nettype none
`include "clk_ctrl_params.svh"
module clk_ctrl
    import clk_ctrl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        clk_en,
    input  wire logic [15:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output var  logic [7:0]  reg_rdata,
    input  wire logic        hs_osc_ready,
    input  wire logic        xtal_tick,
    input  wire logic        stop_exec,
    output var  logic        hs_osc_stop,
    output var  logic        ls_osc_stop,
    output var  logic        pll_enable,
    output var  logic        pll_mode_status,
    output var  logic        main_osc_stop,
    output var  logic        main_clk_is_hs_sys,
    output var  logic        periph_clk_is_hs_sys,
    output var  logic        periph_clk_times_five
);
    localparam int PLL_WAIT = `PLL_WAIT_CYC;

    logic          hs_stable_r;
    logic          pll_on_r;
    logic          pll_sel_r;
    logic          ls_stop_r;
    logic          hs_stop_r;
    logic          main_osc_stop_r;
    logic          system_clock_select_r;
    logic          system_clock_select_used_r;
    logic          msrc_r;
    logic          mcs_r;
    pll_state_type pll_state_r;
    pll_state_type pll_state_nxt;
    logic [11:0]   wait_r;
    logic [11:0]   wait_nxt;
    logic [4:0]    stab_status;

    wire wr_rcm  = reg_wr && (reg_addr == `ADDR_OSC_PLL_CTRL);
    wire wr_mcm  = reg_wr && (reg_addr == `ADDR_MAIN_CLK_MODE);
    wire wr_moc  = reg_wr && (reg_addr == `ADDR_MAIN_OSC_CTRL);
    wire stop_set = wr_moc && reg_wdata[`BIT_MAIN_OSC_STOP] && !main_osc_stop_r;
    wire stab_clear = stop_exec || stop_set;
    wire pll_active = (pll_state_r == PLL_LOCKED) || (pll_state_r == PLL_LEAVING);

    wire [7:0] rcm_view = {hs_stable_r, 1'b0, pll_active, pll_on_r,
                           pll_sel_r, 1'b0, ls_stop_r, hs_stop_r};
    wire [7:0] mcm_view = {5'h00, system_clock_select_r, mcs_r, msrc_r};
    wire [7:0] moc_view = {main_osc_stop_r, 7'h00};
    wire [7:0] stab_counter_status_view = {3'h0, stab_status};

    wire [7:0] rdata_sel =
        (reg_addr == `ADDR_OSC_PLL_CTRL)  ? rcm_view :
        (reg_addr == `ADDR_MAIN_CLK_MODE) ? mcm_view :
        (reg_addr == `ADDR_MAIN_OSC_CTRL) ? moc_view :
        (reg_addr == `ADDR_STAB_STATUS)   ? stab_counter_status_view : 8'h00;

    // PLL sequencing: lock wait, then mode switch timing
    always_comb begin
        pll_state_nxt = pll_state_r;
        wait_nxt      = wait_r;
        case (pll_state_r)
            PLL_THROUGH: begin
                if (pll_on_r && pll_sel_r && wait_r == 12'h000)
                    pll_state_nxt = PLL_LOCKED;
                else if (pll_on_r && wait_r != 12'h000)
                    wait_nxt = wait_r - 12'h001;
            end
            PLL_WAITING: begin
                pll_state_nxt = PLL_THROUGH;
            end
            PLL_LOCKED: begin
                if (!pll_sel_r || !pll_on_r) begin
                    pll_state_nxt = PLL_LEAVING;
                    wait_nxt = 12'(`PLL_DOWN_CYC - 2);
                end
            end
            PLL_LEAVING: begin
                if (wait_r == 12'h000)
                    pll_state_nxt = PLL_THROUGH;
                else
                    wait_nxt = wait_r - 12'h001;
            end
            default: begin
                pll_state_nxt = PLL_THROUGH;
            end
        endcase
        if (pll_state_nxt == PLL_THROUGH && !pll_on_r)
            wait_nxt = 12'(PLL_WAIT);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            hs_stable_r <= 1'b0;
            pll_on_r    <= 1'b0;
            pll_sel_r   <= 1'b0;
            ls_stop_r   <= 1'b0;
            hs_stop_r   <= 1'b0;
            pll_state_r <= PLL_THROUGH;
            wait_r      <= 12'(PLL_WAIT);
        end else if (clk_en) begin
            if (hs_osc_ready)
                hs_stable_r <= 1'b1;
            pll_state_r <= pll_state_nxt;
            wait_r      <= wait_nxt;
            if (wr_rcm) begin
                // Bits 6 and 2 have no storage behind them
                pll_on_r  <= reg_wdata[`BIT_PLL_ENABLE];
                pll_sel_r <= reg_wdata[`BIT_PLL_SELECT];
                ls_stop_r <= reg_wdata[`BIT_LS_STOP];
                hs_stop_r <= reg_wdata[`BIT_HS_STOP];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            main_osc_stop_r     <= 1'b1;
            system_clock_select_r      <= 1'b0;
            system_clock_select_used_r <= 1'b0;
            msrc_r      <= 1'b0;
            mcs_r       <= 1'b0;
        end else if (clk_en) begin
            if (wr_moc)
                main_osc_stop_r <= reg_wdata[`BIT_MAIN_OSC_STOP];
            if (wr_mcm) begin
                msrc_r <= reg_wdata[`BIT_MAIN_SOURCE];
                if (!system_clock_select_used_r && reg_wdata[`BIT_SYS_SELECT] != system_clock_select_r) begin
                    system_clock_select_r      <= reg_wdata[`BIT_SYS_SELECT];
                    system_clock_select_used_r <= 1'b1;
                end
            end
            // Switch only once the crystal clock is running
            mcs_r <= system_clock_select_r && msrc_r && !main_osc_stop_r;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata             <= 8'h00;
            hs_osc_stop           <= 1'b0;
            ls_osc_stop           <= 1'b0;
            pll_enable            <= 1'b0;
            pll_mode_status       <= 1'b0;
            main_osc_stop         <= 1'b1;
            main_clk_is_hs_sys    <= 1'b0;
            periph_clk_is_hs_sys  <= 1'b0;
            periph_clk_times_five <= 1'b0;
        end else if (clk_en) begin
            if (reg_rd)
                reg_rdata <= rdata_sel;
            hs_osc_stop           <= hs_stop_r;
            ls_osc_stop           <= ls_stop_r;
            pll_enable            <= pll_on_r;
            pll_mode_status       <= pll_active;
            main_osc_stop         <= main_osc_stop_r;
            main_clk_is_hs_sys    <= mcs_r;
            periph_clk_is_hs_sys  <= system_clock_select_r && !main_osc_stop_r;
            periph_clk_times_five <= pll_active;
        end
    end

    stab_counter u_stab (
        .clk      (clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .clear    (stab_clear),
        .xtal_tick(xtal_tick),
        .status_r (stab_status)
    );
endmodule // clk_ctrl
`default_nettype wire

// [clk_ctrl_properties.sv]
// Port checker for the clock control block.
// Assumes clk_en stays high while the write timing is judged.
`timescale 1ns/1ns
`default_nettype none
module clk_ctrl_properties
    import clk_ctrl_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        clk_en,
    input wire logic [15:0] reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        hs_osc_ready,
    input wire logic        xtal_tick,
    input wire logic        stop_exec,
    input wire logic        hs_osc_stop,
    input wire logic        ls_osc_stop,
    input wire logic        pll_enable,
    input wire logic        pll_mode_status,
    input wire logic        main_osc_stop,
    input wire logic        main_clk_is_hs_sys,
    input wire logic        periph_clk_is_hs_sys,
    input wire logic        periph_clk_times_five
);
    logic [7:0]  wd1, wd2, wd3;
    logic [11:0] en_cnt;
    // Saturates so a long PLL run cannot wrap back under the wait figure
    always_ff @(posedge clk) begin
        wd1 <= reg_wdata;
        wd2 <= wd1;
        wd3 <= wd2;
        en_cnt <= (reset || !pll_enable) ? 12'h000 : en_cnt + {11'h000, en_cnt != 12'hFFF};
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence seq_ctrl_write;
        clk_en && reg_wr && reg_addr == 16'hFFA0 ##1 (clk_en && !reg_wr)[*3];
    endsequence
    sequence seq_stop_read;
        stop_exec && !xtal_tick ##1 reg_rd && reg_addr == 16'hFFA3 && !xtal_tick;
    endsequence
    a_reset_outputs: assert property ($fell(reset) |-> main_osc_stop && !pll_enable
        && !hs_osc_stop && !pll_mode_status && !main_clk_is_hs_sys) else $error("reset levels");
    a_write_stops: assert property (seq_ctrl_write |-> {ls_osc_stop, hs_osc_stop} == wd3[1:0])
        else $error("stop bits");
    a_write_pll_en: assert property (seq_ctrl_write |-> pll_enable == wd3[4])
        else $error("pll enable");
    a_pll_wait: assert property ($rose(pll_mode_status) |-> en_cnt >= 12'h9BF)
        else $error("pll wait short");
    a_pll_needs_en: assert property ($rose(pll_mode_status) |-> pll_enable)
        else $error("pll mode without enable");
    a_pll_leave: assert property ($fell(pll_enable) |-> ##[0:4] !pll_mode_status)
        else $error("pll leave slow");
    a_periph_five: assert property (periph_clk_times_five == pll_mode_status)
        else $error("periph multiply");
    a_main_periph: assert property (main_clk_is_hs_sys |-> periph_clk_is_hs_sys)
        else $error("main without periph");
    a_stop_clears: assert property (seq_stop_read |=> reg_rdata == 8'h00)
        else $error("stab not cleared");
endmodule // clk_ctrl_properties
bind clk_ctrl clk_ctrl_properties i_clk_ctrl_properties (.clk(clk), .reset(reset),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .hs_osc_ready(hs_osc_ready),
    .xtal_tick(xtal_tick), .stop_exec(stop_exec), .hs_osc_stop(hs_osc_stop),
    .ls_osc_stop(ls_osc_stop), .pll_enable(pll_enable), .pll_mode_status(pll_mode_status),
    .main_osc_stop(main_osc_stop), .main_clk_is_hs_sys(main_clk_is_hs_sys),
    .periph_clk_is_hs_sys(periph_clk_is_hs_sys), .periph_clk_times_five(periph_clk_times_five));
`default_nettype wire

// [clk_ctrl_bench.sv]
// Self-checking bench for the clock control block.
// Assumes the register port and status inputs are driven from here alone.
`timescale 1ns/1ns
`default_nettype none
module clk_ctrl_bench;
    logic        clk = 1'b0, reset = 1'b1, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        hs_osc_ready = 1'b0, xtal_tick = 1'b0, stop_exec = 1'b0, rd_q = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata, d;
    logic        hs_osc_stop, ls_osc_stop, pll_enable, pll_mode_status, main_osc_stop;
    logic        main_clk_is_hs_sys, periph_clk_is_hs_sys, periph_clk_times_five;
    logic [7:0]  exp_q[$];
    int          error_cnt = 0, n_tests = 0, cyc = 0;
    always #2 clk = ~clk;
    clk_ctrl i_clk_ctrl (.clk(clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .hs_osc_ready(hs_osc_ready), .xtal_tick(xtal_tick), .stop_exec(stop_exec),
        .hs_osc_stop(hs_osc_stop), .ls_osc_stop(ls_osc_stop), .pll_enable(pll_enable),
        .pll_mode_status(pll_mode_status), .main_osc_stop(main_osc_stop),
        .main_clk_is_hs_sys(main_clk_is_hs_sys), .periph_clk_is_hs_sys(periph_clk_is_hs_sys),
        .periph_clk_times_five(periph_clk_times_five));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    // A pending stop pulse is dropped here so it lands one edge before the read
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk);
        stop_exec = 1'b0;
        reg_addr = a;
        reg_rd = 1'b1;
        exp_q.push_back(e);
        @(negedge clk);
        reg_rd = 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk) rd_q <= reg_rd && clk_en && !reset;
    always @(negedge clk) begin
        if (rd_q) begin
            chk(reg_rdata, exp_q.pop_front());
        end
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(32'h265283FA));
        idle(10);
        reset = 1'b0;
        rd(16'hFFA0, 8'h00);
        rd(16'hFFA1, 8'h00);
        rd(16'hFFA2, 8'h80);
        rd(16'hFFA3, 8'h00);
        rd(16'hFFA5, 8'h00);
        hs_osc_ready = 1'b1;
        idle(2);
        rd(16'hFFA0, 8'h80);
        wr(16'hFFA0, 8'h23);
        idle(3);
        rd(16'hFFA0, 8'h83);
        // No peripheral hangs off this bench, so oscillator stops are harmless here
        repeat (4) begin
            d = 8'($urandom);
            wr(16'hFFA0, d & 8'hE7);
            idle(3);
            rd(16'hFFA0, 8'h80 | (d & 8'h03));
        end
        // A write while the enable is low must leave every bit as it was
        clk_en = 1'b0;
        wr(16'hFFA0, {6'h00, ~d[1:0]});
        clk_en = 1'b1;
        rd(16'hFFA0, 8'h80 | (d & 8'h03));
        $display("test control done");
        wr(16'hFFA0, 8'h18);
        idle(3);
        rd(16'hFFA0, 8'h98);
        idle(2400);
        rd(16'hFFA0, 8'h98);
        idle(200);
        rd(16'hFFA0, 8'hB8);
        chk({7'h00, periph_clk_times_five}, 8'h01);
        wr(16'hFFA0, 8'h00);
        idle(3);
        rd(16'hFFA0, 8'h80);
        chk({7'h00, periph_clk_times_five}, 8'h00);
        $display("test pll done");
        wr(16'hFFA2, 8'h00);
        idle(3);
        rd(16'hFFA2, 8'h00);
        wr(16'hFFA1, 8'h07);
        idle(3);
        rd(16'hFFA1, 8'h07);
        chk({6'h00, main_clk_is_hs_sys, periph_clk_is_hs_sys}, 8'h03);
        wr(16'hFFA1, 8'h00);
        idle(3);
        rd(16'hFFA1, 8'h04);
        chk({6'h00, main_clk_is_hs_sys, periph_clk_is_hs_sys}, 8'h01);
        $display("test main clock done");
        xtal_tick = 1'b1;
        idle(2100);
        xtal_tick = 1'b0;
        rd(16'hFFA3, 8'h10);
        xtal_tick = 1'b1;
        idle(6200);
        xtal_tick = 1'b0;
        rd(16'hFFA3, 8'h18);
        wr(16'hFFA2, 8'h80);
        idle(2);
        rd(16'hFFA3, 8'h00);
        wr(16'hFFA2, 8'h00);
        xtal_tick = 1'b1;
        idle(2100);
        xtal_tick = 1'b0;
        rd(16'hFFA3, 8'h10);
        stop_exec = 1'b1;
        rd(16'hFFA3, 8'h00);
        idle(2);
        $display("test stabilisation done");
        wrap_up();
    end
endmodule // clk_ctrl_bench
`default_nettype wire
